// File: design/ssw_top.sv
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
// Function
// - Stall detection runs only in ripple-control decay, which is the reset mode.
// - Torque count output refreshed every 8 ms, full scale 4095.
// - By reset default stall detection is off; once enabled, a stall raises the fault and, unless keep-drive is set, stops the drive at once.
// - Stall fault stays latched until host clears it, and blocks drive unless keep-drive is set.
// - Option to keep driving the outputs after a stall.
// - Selectable x8 scaling of the reported torque count.
// - Custom mode ignores built-in resolution and drives from custom table.
// - Eight custom entries of 0 to 255 describe the first quadrant.
// - Other quadrants and zero points are derived by the device.
module ssw_top
    import ssw_pkg::*;
#(
    parameter int TQ_CYCLES = SSW_TQ_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             avs_response_err,
    input  wire logic [11:0] tq_raw,
    input  wire logic        step_pulse,
    input  wire logic        dir_in,
    input  wire logic [3:0]  builtin_res,
    input  wire logic [7:0]  builtin_a,
    input  wire logic [7:0]  builtin_b,
    output logic      [11:0] tq_monitor,
    output logic             bridge_en,
    output logic             dir_out,
    output ssw_phase_s       coil_a,
    output ssw_phase_s       coil_b,
    output logic             stall_fault,
    output logic             irq
);

    ssw_ctrl_s              ctrl_q;
    logic [11:0]            thresh_q;
    logic [11:0]            tq_q;
    logic [1:0]             status_q;
    logic [1:0]             mask_q;
    logic [7:0]             wave_q [SSW_ENTRIES];
    logic [SSW_ENTRIES*8-1:0] wave_flat;
    logic [31:0]            period_cnt_q;
    logic                   tq_tick;
    logic [14:0]            tq_scaled;
    logic [11:0]            tq_d;
    logic                   stall_hit;
    ssw_state_e             state_q;
    ssw_state_e             state_d;
    logic                   fault_clear;
    logic [SSW_IDX_W-1:0]   idx_q;
    ssw_phase_s             lut_a;
    ssw_phase_s             lut_b;
    logic                   ack_q;
    logic                   wr_go;
    logic                   rd_go;
    logic [31:0]            rd_mux;
    logic                   addr_ok;
    logic                   rd_take;
    logic                   wr_ctrl;
    logic                   wr_thresh;
    logic                   wr_mask;
    logic                   wr_status;
    logic                   stall_armed;
    logic [1:0]             status_set;
    logic [SSW_IDX_W-1:0]   idx_d;
    ssw_phase_s             coil_a_d;
    ssw_phase_s             coil_b_d;

    function automatic logic is_wave(input logic [3:0] a);
        return a[3];
    endfunction : is_wave

    function automatic logic reg_wr(input logic go, input logic [3:0] a,
                                    input logic [3:0] target);
        return go && (a == target);
    endfunction : reg_wr

    // Bus slave: one wait cycle, then ack
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign wr_go = avs_write & ack_q;
    assign rd_go = avs_read & ack_q;
    // Read data captured in the wait cycle, so it stands when waitrequest drops
    assign rd_take = avs_read & ~ack_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        if (is_wave(avs_address)) begin
            rd_mux = {24'h00_0000, wave_q[avs_address[2:0]]};
        end else begin
            case (avs_address)
                SSW_ADDR_CTRL:   rd_mux = {25'h000_0000, ctrl_q};
                SSW_ADDR_THRESH: rd_mux = {20'h0_0000, thresh_q};
                SSW_ADDR_TQCNT:  rd_mux = {20'h0_0000, tq_q};
                SSW_ADDR_STATUS: rd_mux = {30'h0000_0000, status_q};
                SSW_ADDR_MASK:   rd_mux = {30'h0000_0000, mask_q};
                SSW_ADDR_FCLR:   rd_mux = 32'h0000_0000;
                default:         addr_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata     <= 32'h0000_0000;
            avs_response_err <= 1'b0;
        end else begin
            if (rd_take) begin
                avs_readdata <= rd_mux;
            end
            avs_response_err <= (rd_go | wr_go) & ~addr_ok;
        end
    end

    // Register write strobes, live only in the acknowledge cycle
    always_comb begin
        wr_ctrl   = reg_wr(wr_go, avs_address, SSW_ADDR_CTRL);
        wr_thresh = reg_wr(wr_go, avs_address, SSW_ADDR_THRESH);
        wr_mask   = reg_wr(wr_go, avs_address, SSW_ADDR_MASK);
        wr_status = reg_wr(wr_go, avs_address, SSW_ADDR_STATUS);
    end

    // Control; ripple decay is the reset mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= ssw_ctrl_s'(SSW_CTRL_RESET);
        end else if (wr_ctrl && avs_byteenable[0]) begin
            ctrl_q <= ssw_ctrl_s'(avs_writedata[6:0]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thresh_q <= 12'h000;
        end else if (wr_thresh) begin
            if (avs_byteenable[0]) begin
                thresh_q[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                thresh_q[11:8] <= avs_writedata[11:8];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= 2'b00;
        end else if (wr_mask && avs_byteenable[0]) begin
            mask_q <= avs_writedata[1:0];
        end
    end

    // Custom table storage, eight 8-bit entries
    genvar gi;
    generate
        for (gi = 0; gi < SSW_ENTRIES; gi++) begin : g_wave
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    wave_q[gi] <= 8'h00;
                end else if (wr_go && is_wave(avs_address)
                             && avs_address[2:0] == 3'(gi) && avs_byteenable[0]) begin
                    wave_q[gi] <= avs_writedata[7:0];
                end
            end
            assign wave_flat[gi*8 +: 8] = wave_q[gi];
        end
    endgenerate

    // Torque count refresh timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            period_cnt_q <= 32'h0000_0000;
        end else if (tq_tick) begin
            period_cnt_q <= 32'h0000_0000;
        end else begin
            period_cnt_q <= period_cnt_q + 32'h0000_0001;
        end
    end
    assign tq_tick = (period_cnt_q == 32'(TQ_CYCLES - 1));

    // x8 scaling saturates at full scale
    always_comb begin
        tq_scaled = ctrl_q.x8 ? {tq_raw, 3'b000} : {3'b000, tq_raw};
        tq_d = (tq_scaled > {3'b000, SSW_TQ_FULL}) ? SSW_TQ_FULL : tq_scaled[11:0];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tq_q <= 12'h000;
        end else if (tq_tick) begin
            tq_q <= tq_d;
        end
    end
    assign tq_monitor = tq_q;

    // Only judged at a fresh count, only in ripple decay
    assign stall_armed = ctrl_q.stall_en && ctrl_q.ripple
                         && (thresh_q != 12'h000);
    assign stall_hit   = tq_tick && stall_armed && (tq_d < thresh_q);

    assign fault_clear = reg_wr(wr_go, avs_address, SSW_ADDR_FCLR)
                         && avs_byteenable[0] && avs_writedata[0];

    // Fault state; a stall in the clear cycle wins
    always_comb begin
        state_d = state_q;
        case (state_q)
            SSW_RUN: begin
                if (stall_hit) begin
                    state_d = ctrl_q.keep_drive ? SSW_KEEP : SSW_STALL;
                end
            end
            SSW_STALL, SSW_KEEP: begin
                if (fault_clear && !stall_hit) begin
                    state_d = SSW_RUN;
                end
            end
            default: state_d = SSW_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= SSW_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    assign stall_fault = (state_q != SSW_RUN);
    // Latched stall blocks drive unless keep-drive chosen
    assign bridge_en = ctrl_q.drive_en && (state_q != SSW_STALL);

    // Reverse option flips direction while faulted
    assign dir_out = dir_in ^ (ctrl_q.reverse && stall_fault);

    // Event sources of the status bits
    always_comb begin
        status_set               = 2'b00;
        status_set[SSW_ST_STALL] = stall_hit;
        status_set[SSW_ST_TQUPD] = tq_tick;
    end

    // Sticky status, set beats clear so no event is lost
    generate
        for (gi = 0; gi < 2; gi++) begin : g_status
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    status_q[gi] <= 1'b0;
                end else if (status_set[gi]) begin
                    status_q[gi] <= 1'b1;
                end else if (wr_status && avs_byteenable[0] && avs_writedata[gi]) begin
                    status_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    assign irq = |(status_q & mask_q);

    // Custom step index, advances only while driving
    always_comb begin
        idx_d = idx_q;
        if (step_pulse && bridge_en && ctrl_q.custom_en) begin
            idx_d = dir_out ? idx_q + 5'h01 : idx_q - 5'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_q <= 5'h00;
        end else begin
            idx_q <= idx_d;
        end
    end

    ssw_wave_lut u_lut (
        .entries (wave_flat),
        .index   (idx_q),
        .phase_a (lut_a),
        .phase_b (lut_b)
    );

    // Built-in resolution ignored entirely in custom mode
    always_comb begin
        coil_a_d = '0;
        coil_b_d = '0;
        if (bridge_en && ctrl_q.custom_en) begin
            coil_a_d = lut_a;
            coil_b_d = lut_b;
        end else if (bridge_en) begin
            coil_a_d = '{sign: builtin_res[3], mag: builtin_a};
            coil_b_d = '{sign: builtin_res[2], mag: builtin_b};
        end
    end

    // Coils fall to zero current while the bridge is off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coil_a <= '0;
            coil_b <= '0;
        end else begin
            coil_a <= coil_a_d;
            coil_b <= coil_b_d;
        end
    end

endmodule : ssw_top

// File: design/ssw_wave_lut.sv
`timescale 1ns/10ps
// Mirrors the first-quadrant table into a full electrical cycle of 32 steps
module ssw_wave_lut
    import ssw_pkg::*;
(
    input  wire logic [SSW_ENTRIES*8-1:0] entries,
    input  wire logic [SSW_IDX_W-1:0]     index,
    output ssw_phase_s                    phase_a,
    output ssw_phase_s                    phase_b
);

    function automatic ssw_phase_s lookup(input logic [SSW_ENTRIES*8-1:0] tbl,
                                          input logic [SSW_IDX_W-1:0] idx);
        logic [2:0] pos;
        logic [3:0] slot;
        ssw_phase_s r;
        pos  = idx[2:0];
        slot = 4'h0;
        r    = '0;
        // Quadrant 0,2 rise from zero; 1,3 fall back; zero points auto inserted
        if (idx[3] == 1'b0) begin
            slot = {1'b0, pos};
        end else begin
            slot = 4'h8 - {1'b0, pos};
        end
        if (slot == 4'h0) begin
            r.mag = 8'h00;
        end else begin
            r.mag = tbl[(slot - 4'h1)*8 +: 8];
        end
        r.sign = idx[4];
        return r;
    endfunction : lookup

    // Phase B leads by a quarter cycle
    assign phase_a = lookup(entries, index);
    assign phase_b = lookup(entries, index + 5'h08);

endmodule : ssw_wave_lut

// File: pkg/ssw_pkg.sv
package ssw_pkg;

    // Avalon-MM word addresses (byte address / 4)
    localparam logic [3:0] SSW_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] SSW_ADDR_THRESH = 4'h1;
    localparam logic [3:0] SSW_ADDR_TQCNT  = 4'h2;
    localparam logic [3:0] SSW_ADDR_STATUS = 4'h3;
    localparam logic [3:0] SSW_ADDR_MASK   = 4'h4;
    localparam logic [3:0] SSW_ADDR_FCLR   = 4'h5;
    localparam logic [3:0] SSW_ADDR_WAVE0  = 4'h8;

    // Control register fields
    localparam int SSW_CTRL_RIPPLE_BIT = 0;
    localparam int SSW_CTRL_STALL_EN   = 1;
    localparam int SSW_CTRL_KEEP_DRIVE = 2;
    localparam int SSW_CTRL_REVERSE    = 3;
    localparam int SSW_CTRL_X8         = 4;
    localparam int SSW_CTRL_CUSTOM_EN  = 5;
    localparam int SSW_CTRL_DRIVE_EN   = 6;
    localparam logic [6:0] SSW_CTRL_RESET = 7'h01;

    // Status / mask bits
    localparam int SSW_ST_STALL = 0;
    localparam int SSW_ST_TQUPD = 1;

    localparam int SSW_TQ_W          = 12;
    localparam logic [11:0] SSW_TQ_FULL = 12'hfff;
    localparam int SSW_TQ_PERIOD_MS  = 8;
    localparam int SSW_CLK_KHZ       = 100000;
    localparam int SSW_TQ_CYCLES     = SSW_TQ_PERIOD_MS * SSW_CLK_KHZ;

    localparam int SSW_ENTRIES = 8;
    localparam int SSW_IDX_W   = 5;

    typedef struct packed {
        logic        drive_en;
        logic        custom_en;
        logic        x8;
        logic        reverse;
        logic        keep_drive;
        logic        stall_en;
        logic        ripple;
    } ssw_ctrl_s;

    typedef struct packed {
        logic       sign;
        logic [7:0] mag;
    } ssw_phase_s;

    typedef enum logic [1:0] {
        SSW_RUN   = 2'b00,
        SSW_STALL = 2'b01,
        SSW_KEEP  = 2'b11
    } ssw_state_e;

endpackage : ssw_pkg

// File: tb/ssw_motor_model.sv
`timescale 1ns/10ps
module ssw_motor_model
    import ssw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        bridge_en,
    input  wire logic [11:0] load_cnt,
    output logic      [11:0] tq_raw
);
    logic [11:0] noise_q;
    // Undriven windings give no real count, so show a moving pattern
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            noise_q <= 12'h5a5;
        end else begin
            noise_q <= noise_q + 12'h3a7;
        end
    end
    assign tq_raw = bridge_en ? load_cnt : noise_q;
endmodule : ssw_motor_model

// File: tb/ssw_top_props.sv
`timescale 1ns/10ps
module ssw_top_props
    import ssw_pkg::*;
#(
    parameter int TQ_CYCLES = SSW_TQ_CYCLES
)
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        avs_response_err,
    input wire logic [11:0] tq_monitor,
    input wire logic        bridge_en,
    input wire logic        dir_in,
    input wire logic        dir_out,
    input wire logic        stall_fault
);
    logic [6:0]  ctrl_q;
    logic [11:0] thr_q;
    int          gap_q;
    logic        seen_q;
    wire         wr_done = avs_write && !avs_waitrequest;
    wire         clr_done = wr_done && avs_address == SSW_ADDR_FCLR && avs_writedata[0];
    wire         bad_addr = avs_address == 4'h6 || avs_address == 4'h7;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow of the configuration, since the checker sees only ports
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= SSW_CTRL_RESET;
            thr_q  <= 12'h000;
            gap_q  <= 0;
            seen_q <= 1'b0;
        end else begin
            if (wr_done && avs_address == SSW_ADDR_CTRL) ctrl_q <= avs_writedata[6:0];
            if (wr_done && avs_address == SSW_ADDR_THRESH) thr_q <= avs_writedata[11:0];
            gap_q  <= $changed(tq_monitor) ? 1 : gap_q + 1;
            seen_q <= seen_q || $changed(tq_monitor);
        end
    end
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered without wait cycle");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held too long");
    a_err_pulse: assert property ((avs_read || avs_write) && !avs_waitrequest
        |=> avs_response_err == $past(bad_addr)) else $error("response error wrong");
    a_drive_gate: assert property (bridge_en |-> ctrl_q[SSW_CTRL_DRIVE_EN] &&
        (!stall_fault || ctrl_q[SSW_CTRL_KEEP_DRIVE])) else $error("drive while blocked");
    a_fault_held: assert property (stall_fault && !clr_done |=> stall_fault)
        else $error("fault dropped without clear");
    a_stall_cause: assert property ($rose(stall_fault) |-> ctrl_q[0] && ctrl_q[1] &&
        thr_q != 12'h000 && tq_monitor < thr_q) else $error("stall without cause");
    a_tq_period: assert property ($changed(tq_monitor) && seen_q |-> gap_q % TQ_CYCLES == 0)
        else $error("torque count off its refresh period");
    a_dir_flip: assert property (dir_out == (dir_in ^ (stall_fault && ctrl_q[SSW_CTRL_REVERSE])))
        else $error("direction output wrong");
    cover property (stall_fault && !bridge_en);
    cover property (stall_fault && bridge_en);
    cover property (avs_response_err);
endmodule : ssw_top_props

bind ssw_top ssw_top_props #(.TQ_CYCLES(TQ_CYCLES)) ssw_top_props_inst (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err), .tq_monitor(tq_monitor), .bridge_en(bridge_en),
    .dir_in(dir_in), .dir_out(dir_out), .stall_fault(stall_fault));

// File: tb/tb_ssw_top.sv
`timescale 1ns/10ps
module tb_ssw_top
    import ssw_pkg::*;
;
    localparam int TQ = 50;
    logic        clk, rst, avs_read, avs_write, step_pulse, dir_in, err, f;
    logic        avs_waitrequest, avs_response_err, bridge_en, dir_out, stall_fault, irq;
    logic [3:0]  avs_address, builtin_res;
    logic [7:0]  builtin_a, builtin_b, mode[5];
    logic [11:0] tq_raw, tq_monitor, load_cnt, thr[5];
    logic [15:0] lfsr;
    logic [31:0] avs_writedata, avs_readdata, rd;
    ssw_phase_s  coil_a, coil_b;
    int          bad_count, comparisons, e, tbl[8];
    ssw_top #(.TQ_CYCLES(TQ)) ssw_top_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response_err(avs_response_err), .tq_raw(tq_raw), .step_pulse(step_pulse),
        .dir_in(dir_in), .builtin_res(builtin_res), .builtin_a(builtin_a), .builtin_b(builtin_b),
        .tq_monitor(tq_monitor), .bridge_en(bridge_en), .dir_out(dir_out), .coil_a(coil_a),
        .coil_b(coil_b), .stall_fault(stall_fault), .irq(irq));
    ssw_motor_model ssw_motor_model_inst (.clk(clk), .rst(rst), .bridge_en(bridge_en),
        .load_cnt(load_cnt), .tq_raw(tq_raw));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    function automatic logic [8:0] wave(input int i);
        int p;
        int q;
        p = i % 8;
        q = (i / 8) % 4;
        return {q >= 2, 8'(q % 2 == 0 ? (p == 0 ? 0 : tbl[p - 1]) : tbl[7 - p])};
    endfunction : wave
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("compared %0d, wrong %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
        err = avs_response_err;
    endtask : bus
    task automatic restart();
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b1, SSW_ADDR_MASK, 32'h1);
    endtask : restart
    initial begin
        repeat (6000) @(posedge clk);
        bad_count++;
        finish_test();
    end
    initial begin
        {rst, avs_read, avs_write, step_pulse, dir_in} = 5'h11;
        {avs_address, avs_writedata, builtin_res, builtin_a, builtin_b} = '0;
        {bad_count, comparisons} = '0;
        load_cnt = 12'h7d0;
        lfsr = 16'h59e1;
        mode = '{8'h43, 8'h47, 8'h43, 8'h42, 8'h4b};
        thr = '{12'h3e8, 12'h3e8, 12'h000, 12'h3e8, 12'h3e8};
        restart();
        bus(1'b0, SSW_ADDR_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h1);
        bus(1'b0, 4'h6, 32'h0);
        check("unmapped data", rd, 32'h0);
        check("unmapped err", err, 32'h1);
        bus(1'b1, SSW_ADDR_THRESH, 32'hfabc);
        bus(1'b0, SSW_ADDR_THRESH, 32'h0);
        check("threshold", rd, 32'habc);
        $display("register test done");
        for (int k = 0; k < 4; k++) begin
            load_cnt <= k < 2 ? {3'h0, lfsr[8:0]} : 12'h258;
            lfsr = nxt(lfsr);
            bus(1'b1, SSW_ADDR_CTRL, 32'h41 + 32'(k % 2) * 32'h10);
            repeat (TQ + 4) @(posedge clk);
            e = (k % 2 ? 8 : 1) * int'(load_cnt);
            e = e > 4095 ? 4095 : e;
            bus(1'b0, SSW_ADDR_TQCNT, 32'h0);
            check("torque monitor", tq_monitor, 32'(e));
            check("torque register", rd, 32'(e));
        end
        bus(1'b0, SSW_ADDR_STATUS, 32'h0);
        check("status", rd, 32'h2);
        $display("torque test done");
        for (int c = 0; c < 5; c++) begin
            restart();
            load_cnt <= 12'h7d0;
            bus(1'b1, SSW_ADDR_THRESH, 32'(thr[c]));
            bus(1'b1, SSW_ADDR_CTRL, 32'(mode[c]));
            repeat (TQ + 4) @(posedge clk);
            check("fault at normal load", stall_fault, 32'h0);
            load_cnt <= 12'h1f4;
            repeat (TQ + 4) @(posedge clk);
            f = mode[c][1] && mode[c][0] && thr[c] != 12'h000;
            check("fault", stall_fault, 32'(f));
            check("irq", irq, 32'(f));
            check("drive", bridge_en, 32'(!f || mode[c][2]));
            check("direction", dir_out, 32'(!(f && mode[c][3])));
            load_cnt <= 12'h7d0;
            repeat (TQ + 4) @(posedge clk);
            check("fault held", stall_fault, 32'(f));
            bus(1'b1, SSW_ADDR_THRESH, 32'h0);
            bus(1'b1, SSW_ADDR_FCLR, 32'h1);
            bus(1'b1, SSW_ADDR_STATUS, 32'h3);
            check("fault cleared", stall_fault, 32'h0);
            check("irq cleared", irq, 32'h0);
        end
        $display("stall test done");
        restart();
        for (int i = 0; i < 8; i++) begin
            tbl[i] = int'(lfsr[7:0]);
            lfsr = nxt(lfsr);
            bus(1'b1, SSW_ADDR_WAVE0 + 4'(i), 32'(tbl[i]));
        end
        bus(1'b1, SSW_ADDR_CTRL, 32'h61);
        for (int s = 0; s < 33; s++) begin
            if (s > 0) begin
                step_pulse <= 1'b1;
                {builtin_res, builtin_a, builtin_b} <= {lfsr[3:0], lfsr};
                lfsr = nxt(lfsr);
                @(posedge clk);
                step_pulse <= 1'b0;
            end
            repeat (3) @(posedge clk);
            check("coil a", coil_a, 32'(wave(s)));
            check("coil b", coil_b, 32'(wave(s + 8)));
        end
        bus(1'b1, SSW_ADDR_CTRL, 32'h41);
        @(posedge clk);
        check("coil builtin", coil_a, {23'h0, builtin_res[3], builtin_a});
        $display("custom wave test done");
        finish_test();
    end
endmodule : tb_ssw_top
